/* hdl/dfp_top.sv */
// dual fast pwm with its axi4-lite register slave
`timescale 1ns/1ns
`include "dfp_map.svh"

module dfp_top (
	input wire logic clk, // 20 MHz source clock
	input wire logic rst, // async reset, active high
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic port_latch_a, // port output latch of pin a
	input wire logic port_latch_b, // port output latch of pin b
	output logic shared_port_pin_a, // pin a, pulse output 0
	output logic shared_port_pin_b // pin b, pulse output 1
);

	// -----------------------------------------------------------------
	// declarations
	// -----------------------------------------------------------------
	dfp_pkg::dfp_ctrl_s ctrl_ff;
	dfp_pkg::dfp_wreq_s wreq;
	logic [7:0] duty_ff [2];
	logic [7:0] cnt_ff;
	logic frame_ff;
	logic [7:0] mask;
	logic [7:0] phase;
	logic period_end;
	logic [1:0] low_ff;
	logic [1:0] ext_ff;
	logic [1:0] ext_n_ff;
	logic [1:0] pulse_out;
	logic [1:0] chan_en;
	logic aw_got_ff;
	logic w_got_ff;
	logic [5:0] aw_idx_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic aw_now;
	logic w_now;
	logic do_write;
	logic wr_hit;
	logic do_read;
	logic [5:0] rd_idx;
	logic rd_hit;
	logic [7:0] rd_val;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;

	// -----------------------------------------------------------------
	// axi4-lite write channel
	// -----------------------------------------------------------------
	// address and data are taken independently, in either order
	assign s_axi_awready = !aw_got_ff && !bvalid_ff;
	assign s_axi_wready = !w_got_ff && !bvalid_ff;
	assign aw_now = aw_got_ff || (s_axi_awvalid && s_axi_awready);
	assign w_now = w_got_ff || (s_axi_wvalid && s_axi_wready);
	assign do_write = aw_now && w_now && !bvalid_ff;

	// current write request, held or straight from the bus
	always_comb begin
		wreq.index = aw_got_ff ? aw_idx_ff : s_axi_awaddr[7:2];
		wreq.data = w_got_ff ? w_data_ff : s_axi_wdata;
		wreq.strb = w_got_ff ? w_strb_ff : s_axi_wstrb;
		wr_hit = (wreq.index == `DFP_IDX_CONTROL) ||
			(wreq.index == `DFP_IDX_DUTY0) ||
			(wreq.index == `DFP_IDX_DUTY1);
	end

	// hold a half that arrived early
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			aw_idx_ff <= 6'h00;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
		end else begin
			if (do_write) begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_got_ff <= 1'b1;
					aw_idx_ff <= s_axi_awaddr[7:2];
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_got_ff <= 1'b1;
					w_data_ff <= s_axi_wdata;
					w_strb_ff <= s_axi_wstrb;
				end
			end
		end
	end

	// write response, slverr on an unmapped index
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= `DFP_RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wr_hit ? `DFP_RESP_OKAY : `DFP_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// control register, unused bits forced to zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_ff <= `DFP_CTRL_RESET; // see R12
		end else if (do_write && wreq.strb[0] &&
			wreq.index == `DFP_IDX_CONTROL) begin
			ctrl_ff <= wreq.data[7:0] & `DFP_CTRL_WMASK;
		end
	end

	// -----------------------------------------------------------------
	// axi4-lite read channel
	// -----------------------------------------------------------------
	assign s_axi_arready = !rvalid_ff;
	assign do_read = s_axi_arvalid && s_axi_arready;
	assign rd_idx = s_axi_araddr[7:2];

	// read mux
	always_comb begin
		rd_hit = 1'b1;
		unique case (rd_idx)
			`DFP_IDX_CONTROL: rd_val = ctrl_ff;
			`DFP_IDX_DUTY0: rd_val = duty_ff[0];
			`DFP_IDX_DUTY1: rd_val = duty_ff[1];
			default: begin
				rd_val = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	// read data held until rready
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= `DFP_RESP_OKAY;
		end else if (do_read) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= {24'h00_0000, rd_val};
			rresp_ff <= rd_hit ? `DFP_RESP_OKAY : `DFP_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	// -----------------------------------------------------------------
	// shared counter
	// -----------------------------------------------------------------
	// period mask from the common width mode, reserved acts as 8-bit
	always_comb begin
		case (ctrl_ff.width_mode_sel) // see R03, R13
			`DFP_MODE_7BIT: mask = `DFP_MASK_7BIT;
			`DFP_MODE_6BIT: mask = `DFP_MASK_6BIT;
			default: mask = `DFP_MASK_8BIT;
		endcase
	end
	assign phase = cnt_ff & mask;
	assign period_end = (phase == mask);

	// counter and pulse index, cleared while stopped
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= 8'h00;
			frame_ff <= 1'b0;
		end else if (!ctrl_ff.counter_run) begin
			cnt_ff <= 8'h00; // see R04, R07
			frame_ff <= 1'b0;
		end else begin
			cnt_ff <= cnt_ff + 8'h01; // see R04
			frame_ff <= frame_ff ^ period_end; // see R16
		end
	end

	assign chan_en = {ctrl_ff.out1_enable, ctrl_ff.out0_enable};

	// -----------------------------------------------------------------
	// per-channel comparators
	// -----------------------------------------------------------------
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		logic [7:0] whole;
		logic [1:0] halves;
		logic [7:0] width;
		logic on;

		// duty register of this channel
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				duty_ff[ch] <= `DFP_DUTY_RESET;
			end else if (do_write && wreq.strb[0] &&
				wreq.index == `DFP_IDX_DUTY0 + 6'(ch)) begin
				duty_ff[ch] <= wreq.data[7:0]; // see R01
			end
		end

		// whole clocks and half-clock steps of this pulse
		always_comb begin
			whole = duty_ff[ch]; // see R14
			halves = 2'b00;
			case (ctrl_ff.width_mode_sel)
				`DFP_MODE_7BIT: begin
					whole = {1'b0, duty_ff[ch][7:1]}; // see R15
					halves = {1'b0, duty_ff[ch][0]};
				end
				`DFP_MODE_6BIT: begin
					whole = {2'b00, duty_ff[ch][7:2]}; // see R16
					if (frame_ff)
						halves = {1'b0, duty_ff[ch][1]};
					else
						halves = {&duty_ff[ch][1:0], ^duty_ff[ch][1:0]};
				end
				default: begin
				end
			endcase
			width = whole + {7'h00, halves[1]};
			on = ctrl_ff.counter_run && chan_en[ch]; // see R05, R07
		end

		// low from period start, then half-clock tail
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				low_ff[ch] <= 1'b0;
				ext_ff[ch] <= 1'b0;
			end else begin
				low_ff[ch] <= on && (phase < width); // see R17
				ext_ff[ch] <= on && halves[0] && (phase == width);
			end
		end

		// falling-edge copy ends the tail after half a clock
		always_ff @(negedge clk or posedge rst) begin
			if (rst)
				ext_n_ff[ch] <= 1'b0;
			else
				ext_n_ff[ch] <= ext_ff[ch]; // see R11
		end

		// active-low pulse, high when idle
		assign pulse_out[ch] = !(low_ff[ch] ||
			(ext_ff[ch] && !ext_n_ff[ch]));
	end

	// pins combine pulse with port latch
	assign shared_port_pin_a = port_latch_a && pulse_out[0]; // see R02
	assign shared_port_pin_b = port_latch_b && pulse_out[1]; // see R02

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	cnt_hold_a: assert property (!ctrl_ff.counter_run |=> cnt_ff == 8'h00) // see R04
		else $error("counter not held at zero");
	cnt_step_a: assert property (ctrl_ff.counter_run |=>
		cnt_ff == $past(cnt_ff) + 8'h01) // see R04
		else $error("counter did not step");
	stopped_high_a: assert property (!ctrl_ff.counter_run [*2] |->
		pulse_out == 2'b11) // see R07
		else $error("pulse low while stopped");
	dis_high_a: assert property (!ctrl_ff.out0_enable [*2] |->
		pulse_out[0]) // see R05
		else $error("disabled channel pulsed");
	pulse_low_a: assert property (ctrl_ff.counter_run && chan_en[0] &&
		ctrl_ff.width_mode_sel == `DFP_MODE_8BIT && phase == 8'h00 &&
		duty_ff[0] != 8'h00 |=> !pulse_out[0]) // see R14, R17
		else $error("pulse not low at period start");
	pulse_high_a: assert property (ctrl_ff.counter_run && chan_en[0] &&
		ctrl_ff.width_mode_sel == `DFP_MODE_8BIT &&
		phase >= duty_ff[0] |=> pulse_out[0]) // see R14, R17
		else $error("pulse low beyond duty");
	half_ext_a: assert property (ctrl_ff.counter_run && chan_en[1] &&
		ctrl_ff.width_mode_sel == `DFP_MODE_7BIT && duty_ff[1][0] &&
		phase == {1'b0, duty_ff[1][7:1]} |=> ext_ff[1]) // see R15
		else $error("missing half-clock tail");
	period_a: assert property (ctrl_ff.counter_run &&
		ctrl_ff.width_mode_sel == `DFP_MODE_6BIT && period_end &&
		$stable(ctrl_ff) |-> $past(phase, 63) == 8'h00 ||
		!$past(ctrl_ff.counter_run, 63)) // see R13
		else $error("6-bit period not 64 clocks");
	reset_ctrl_a: assert property ($fell(rst) |-> ctrl_ff == 8'h00) // see R12
		else $error("control not zero after reset");
	bvalid_hold_a: assert property (bvalid_ff && !s_axi_bready |=>
		bvalid_ff && $stable(bresp_ff))
		else $error("write response dropped");
	rvalid_hold_a: assert property (rvalid_ff && !s_axi_rready |=>
		rvalid_ff && $stable(rdata_ff))
		else $error("read data dropped");

	write_c: cover property (do_write && wr_hit);
	mode6_c: cover property (ctrl_ff.counter_run &&
		ctrl_ff.width_mode_sel == `DFP_MODE_6BIT && ext_ff[0]);
	pulse_c: cover property ($fell(pulse_out[0]) ##[1:255]
		$rose(pulse_out[0]));

endmodule

/* include/dfp_map.svh */
// register map, field positions and codes of the dual fast pwm
// Functional notes
// R01 - two independent pulse outputs, each shaped by its own duty register.
// R02 - software sets both shared port latches to one before using pulses.
// R03 - width mode 00 is 8-bit, 01 is 7-bit, 10 is 6-bit, 11 is reserved.
// R04 - the run bit stops the shared 8-bit counter at zero, else it counts.
// R05 - each channel has an enable bit: zero disables, one enables output.
// R06 - software writes only duty values 10h through F0h.
// R07 - while stopped the counter is held at zero and both pins drive one.
// R08 - software clears the run bit before changing the width mode.
// R09 - software clears run and both enables before deep standby.
// R10 - software changes an enable bit only while the counter is stopped.
// R11 - the half-clock step uses the falling edge, so clock duty matters.
// R12 - after reset enable, run and mode bits read zero.
// R13 - mode is common; period is 2^8, 2^7 or 2^6 clocks.
// R14 - in 8-bit mode the low width is the duty value in whole clocks.
// R15 - in 7-bit mode the top seven bits count clocks, bit 0 adds half.
// R16 - in 6-bit mode the two low bits dither half-clock steps over pulses.
// R17 - an enabled output is low from period start for the width, then high.
`ifndef DFP_MAP_SVH
`define DFP_MAP_SVH

// -----------------------------------------------------------------
// register indices, the byte address is four times the index
// -----------------------------------------------------------------
`define DFP_IDX_CONTROL 6'h0c
`define DFP_IDX_DUTY0 6'h0d
`define DFP_IDX_DUTY1 6'h0e

// -----------------------------------------------------------------
// control fields and codes
// -----------------------------------------------------------------
`define DFP_CTRL_RESET 8'h00
`define DFP_CTRL_WMASK 8'hcb
`define DFP_MODE_8BIT 2'h0
`define DFP_MODE_7BIT 2'h1
`define DFP_MODE_6BIT 2'h2
`define DFP_MASK_8BIT 8'hff
`define DFP_MASK_7BIT 8'h7f
`define DFP_MASK_6BIT 8'h3f
`define DFP_DUTY_RESET 8'h00
`define DFP_RESP_OKAY 2'h0
`define DFP_RESP_SLVERR 2'h2

`endif

/* include/dfp_pkg.sv */
// types shared by the dual fast pwm
package dfp_pkg;

	// control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic out1_enable;
		logic out0_enable;
		logic [1:0] spare_hi;
		logic counter_run;
		logic spare_lo;
		logic [1:0] width_mode_sel;
	} dfp_ctrl_s;

	// one write request held by the bus slave
	typedef struct packed {
		logic [5:0] index;
		logic [31:0] data;
		logic [3:0] strb;
	} dfp_wreq_s;

endpackage

/* sim/testbench.sv */
// self-checking testbench of the dual fast pwm
`timescale 1ns/1ns

module testbench;
	logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic latch_a, latch_b, pin_a, pin_b;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	int n_errors, n_compared, seed;

	// -----------------------------------------------------------------
	// clock and device under test
	// -----------------------------------------------------------------
	initial clk = 1'b0;
	// 50 ns period
	always #25 clk = ~clk;

	dfp_top i_dfp_top (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .port_latch_a(latch_a),
		.port_latch_b(latch_b), .shared_port_pin_a(pin_a),
		.shared_port_pin_b(pin_b));

	// -----------------------------------------------------------------
	// compare, verdict and bus tasks
	// -----------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// a wait ran out of its bound
	task automatic hang();
		check(32'h0000_0000, 32'h0000_0001);
		print_verdict();
	endtask

	// handshakes are judged at the falling edge, released after the rise
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic ta, tw, tb;
		int n;
		r = 2'h3;
		tb = 1'b0;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50 && !tb; n++) begin
			@(negedge clk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid & bready;
			if (tb)
				r = bresp;
			@(posedge clk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			if (tb)
				bready <= 1'b0;
		end
		if (!tb)
			hang();
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ta, tr;
		int n;
		tr = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50 && !tr; n++) begin
			@(negedge clk);
			ta = arvalid & arready;
			tr = rvalid & rready;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ta)
				arvalid <= 1'b0;
			if (tr)
				rready <= 1'b0;
		end
		if (!tr)
			hang();
	endtask

	// write one register and expect an okay answer
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [1:0] r;
		axi_write(a, {24'h00_0000, d}, r);
		check({30'h0000_0000, r}, 32'h0000_0000);
	endtask

	// -----------------------------------------------------------------
	// pin watching, one sample just after each clock edge
	// -----------------------------------------------------------------
	function automatic logic pin(input int ch);
		return ch ? pin_b : pin_a;
	endfunction

	// the first look waits 1 ns so a pin launched at this edge has settled
	task automatic wait_pin(input int ch, input logic lvl, output int c);
		#1;
		for (c = 0; c < 1200 && pin(ch) !== lvl; c++)
			@(clk) #1;
		if (c == 1200)
			hang();
	endtask

	task automatic count_lvl(input int ch, input logic lvl, output int c);
		int n;
		c = 0;
		for (n = 0; n < 512; n++) begin
			@(clk) #1;
			if (pin(ch) === lvl)
				c++;
		end
	endtask

	// low half-clocks expected; 6-bit mode sums two pulses
	function automatic int exp_low(input int m, input logic [7:0] d);
		if (m == 0)
			return 2 * d;
		if (m == 1)
			return 2 * d[7:1] + d[0];
		return 4 * d[7:2] + d[1:0];
	endfunction

	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial begin
		int m, t, ch, lo, hi, lo2, hi2;
		logic [31:0] rd;
		logic [1:0] r;
		logic [7:0] duty [2];
		seed = 18;
		n_errors = 0;
		n_compared = 0;
		{rst, latch_a, latch_b, wstrb} = 7'h7f;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata} = 48'h0000_0000_0000;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		axi_read(8'h30, rd, r);
		check(rd, 32'h0000_0000);
		count_lvl(0, 1'b0, lo);
		count_lvl(1, 1'b0, hi);
		check(lo + hi, 32'h0000_0000);
		axi_read(8'h3c, rd, r);
		check({30'h0000_0000, r}, 32'h0000_0002);
		axi_write(8'h3c, 32'h0000_00ff, r);
		check({30'h0000_0000, r}, 32'h0000_0002);
		wr(8'h30, 8'hff);
		axi_read(8'h30, rd, r);
		check(rd, 32'h0000_00cb);
		wr(8'h30, 8'hc3);
		wr(8'h30, 8'h00);
		$display("test registers done");
		// each of the three width modes, corner duties first, then random ones
		for (m = 0; m < 3; m++) begin
			for (t = 0; t < 3; t++) begin
				duty[0] = t ? 8'h10 + 8'({$random(seed)} % 225) : 8'h10;
				duty[1] = t ? 8'h10 + 8'({$random(seed)} % 225) : 8'hf0;
				// odd duty in range, so the half-clock tail is reached in 7-bit and 6-bit modes
				if (t == 1)
					duty[1] = 8'h11 | (duty[1] & 8'h6e);
				wr(8'h30, 8'(m));
				wr(8'h34, duty[0]);
				wr(8'h38, duty[1]);
				axi_read(8'h34, rd, r);
				check(rd, {24'h00_0000, duty[0]});
				wr(8'h30, 8'hc8 | 8'(m));
				for (ch = 0; ch < 2; ch++) begin
					wait_pin(ch, 1'b1, lo);
					wait_pin(ch, 1'b0, lo);
					wait_pin(ch, 1'b1, lo);
					wait_pin(ch, 1'b0, hi);
					check(lo + hi, 2 << (8 - m));
					if (m == 2) begin
						wait_pin(ch, 1'b1, lo2);
						wait_pin(ch, 1'b0, hi2);
						lo += lo2;
					end
					check(lo, exp_low(m, duty[ch]));
				end
				wr(8'h30, 8'(m));
			end
			$display("test mode %0d done", m);
		end
		// only channel 0 enabled, then latch a cleared
		wr(8'h30, 8'h48);
		count_lvl(1, 1'b0, lo);
		check(lo, 32'h0000_0000);
		@(posedge clk);
		latch_a <= 1'b0;
		count_lvl(0, 1'b1, lo);
		check(lo, 32'h0000_0000);
		@(posedge clk);
		latch_a <= 1'b1;
		wr(8'h30, 8'h40);
		wr(8'h30, 8'hc0);
		count_lvl(0, 1'b0, lo);
		count_lvl(1, 1'b0, hi);
		check(lo + hi, 32'h0000_0000);
		// everything off, as before deep standby
		wr(8'h30, 8'h00);
		count_lvl(0, 1'b0, lo);
		count_lvl(1, 1'b0, hi);
		check(lo + hi, 32'h0000_0000);
		$display("test enables and stop done");
		print_verdict();
	end
endmodule
